// [rtl/pdma_defs.vh]
// Purpose: shared constants for the data-move and arithmetic unit
// Assumes: 16-bit operand store words, 100 MHz scan clock
// Notes: opcode encodings are local to this block
`ifndef PDMA_DEFS_VH
`define PDMA_DEFS_VH

// ****************************
// opcodes
// ****************************
`define PDMA_OP_BLKCPY 4'h0
`define PDMA_OP_FILL 4'h1
`define PDMA_OP_XCHG 4'h2
`define PDMA_OP_ADD 4'h3
`define PDMA_OP_SUB 4'h4
`define PDMA_OP_MUL 4'h5
`define PDMA_OP_DIV 4'h6
`define PDMA_OP_REM 4'h7
`define PDMA_OP_INC 4'h8
`define PDMA_OP_DEC 4'h9
`define PDMA_OP_AND 4'hA

// ****************************
// widths, divider cycle count and reset values
// ****************************
`define PDMA_WORD_W 16
`define PDMA_ADDR_W 16
`define PDMA_DIV_CYCLES 6'h20
`define PDMA_ZERO16 16'h0000

`endif

// [rtl/pdma_divider.v]
// Purpose: signed restoring divider giving quotient and remainder
// Assumes: start is a one-cycle pulse, divisor is nonzero
// Notes: quotient truncates toward zero, remainder takes the dividend sign
`timescale 1ns/1ps
`include "pdma_defs.vh"
module pdma_divider (
  input wire clk,
  input wire rst_n,
  input wire start,
  input wire [31:0] dividend,
  input wire [31:0] divisor,
  output reg [31:0] quotient,
  output reg [31:0] remainder,
  output reg done
);
  reg [31:0] num_q;
  reg [31:0] den_q;
  reg [31:0] rem_q;
  reg [5:0] cnt_q;
  reg busy_q;
  reg qneg_q;
  reg rneg_q;
  wire [32:0] trial;

  function [31:0] mag;
    input [31:0] v;
    begin
      mag = v[31] ? (~v + 32'h00000001) : v;
    end
  endfunction

  assign trial = {rem_q, num_q[31]} - {1'b0, den_q};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      num_q <= 32'h00000000;
      den_q <= 32'h00000000;
      rem_q <= 32'h00000000;
      cnt_q <= 6'h00;
      busy_q <= 1'b0;
      qneg_q <= 1'b0;
      rneg_q <= 1'b0;
      quotient <= 32'h00000000;
      remainder <= 32'h00000000;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        num_q <= mag(dividend);
        den_q <= mag(divisor);
        rem_q <= 32'h00000000;
        cnt_q <= `PDMA_DIV_CYCLES;
        busy_q <= 1'b1;
        qneg_q <= dividend[31] ^ divisor[31];
        rneg_q <= dividend[31];
      end else if (busy_q) begin
        if (!trial[32]) begin
          rem_q <= trial[31:0];
          num_q <= {num_q[30:0], 1'b1};
        end else begin
          rem_q <= {rem_q[30:0], num_q[31]};
          num_q <= {num_q[30:0], 1'b0};
        end
        cnt_q <= cnt_q - 6'h01;
        if (cnt_q == 6'h01) begin
          busy_q <= 1'b0;
          done <= 1'b1;
        end
      end
      if (busy_q && cnt_q == 6'h00) begin
        busy_q <= 1'b0;
      end
      if (done) begin
        quotient <= qneg_q ? (~num_q + 32'h00000001) : num_q;
        remainder <= rneg_q ? (~rem_q + 32'h00000001) : rem_q;
      end
    end
  end
endmodule // pdma_divider

// [rtl/pdma_edge.v]
// Purpose: rising-edge detector for an instruction's entry condition
// Assumes: enable is synchronous to CLK_SYS
// Notes: rise is combinational and stays high until an enabled cycle samples level into prev_q
`timescale 1ns/1ps
module pdma_edge (
  input wire clk,
  input wire rst_n,
  input wire level,
  input wire enable,
  output wire rise
);
  reg prev_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= 1'b0;
    end else if (enable) begin
      prev_q <= level;
    end
  end

  assign rise = level & ~prev_q;
endmodule // pdma_edge

// [rtl/pdma_unit.v]
// Purpose: execution datapath for data-move and arithmetic instructions
// Assumes: operand store answers a read in the same cycle that MEM_RD is high
// Notes: one instruction at a time; START is taken only while READY is high
//
// Behaviour
// - block copy moves n elements, both addresses stepping by element size.
// - fill writes the one source value into n consecutive destinations.
// - exchange swaps the contents of its two destination operands.
// - addition adds both sources as signed values into the destination.
// - subtraction stores first source minus second as a signed value.
// - multiplication stores the signed product of the two sources, cut to the operand width (low 16 bits in the narrow form).
// - division stores only the truncated signed quotient.
// - remainder stores the signed remainder of the division.
// - the top bit of every arithmetic result is its sign, 1 for negative.
// - a 32-bit operand is the named word low and the next word high.
// - division or remainder by zero raises an error and writes nothing.
// - the pulse form runs once per rising edge of its entry condition.
// - bitwise AND sets a bit only where both source bits are 1, in 16 or 32 bits.
`timescale 1ns/1ps
`include "pdma_defs.vh"
module pdma_unit (
  input wire CLK_SYS,
  input wire RSTN,
  input wire START,
  input wire [3:0] OPCODE,
  input wire WIDE,
  input wire PULSE_FORM,
  input wire ENTRY_COND,
  input wire [15:0] SRC1_ADDR,
  input wire [15:0] SRC2_ADDR,
  input wire [15:0] DST_ADDR,
  input wire [15:0] COUNT,
  output wire READY,
  output reg DONE,
  output reg DIV_ZERO_ERR,
  output reg MEM_RD,
  output reg MEM_WR,
  output reg [15:0] MEM_ADDR,
  output reg [15:0] MEM_WDATA,
  input wire [15:0] MEM_RDATA
);
  // ****************************
  // states
  // ****************************
  localparam ST_IDLE = 4'h0;
  localparam ST_RD = 4'h1;
  localparam ST_RWAIT = 4'h2;
  localparam ST_EXEC = 4'h3;
  localparam ST_DIVW = 4'h4;
  localparam ST_WR = 4'h5;
  localparam ST_NEXT = 4'h6;
  localparam ST_FIN = 4'h7;

  reg [3:0] state_q;
  reg [3:0] op_q;
  reg wide_q;
  reg [15:0] s1_q;
  reg [15:0] s2_q;
  reg [15:0] d_q;
  reg [15:0] n_q;
  reg [2:0] rcnt_q;
  reg [2:0] rtot_q;
  reg [2:0] wcnt_q;
  reg [2:0] wtot_q;
  reg [31:0] a_q;
  reg [31:0] b_q;
  reg [31:0] r_q;
  reg [31:0] r2_q;
  reg div_go_q;
  wire rise;
  wire fire;
  wire [31:0] quo;
  wire [31:0] rem;
  wire div_done;
  wire [15:0] step;
  wire stream;

  pdma_edge u_edge (
    .clk(CLK_SYS),
    .rst_n(RSTN),
    .level(ENTRY_COND),
    .enable(START & READY),
    .rise(rise)
  );

  assign READY = (state_q == ST_IDLE);
  assign fire = START & READY & (PULSE_FORM ? rise : ENTRY_COND);
  assign step = wide_q ? 16'h0002 : 16'h0001;
  assign stream = (op_q == `PDMA_OP_BLKCPY) || (op_q == `PDMA_OP_FILL);

  pdma_divider u_div (
    .clk(CLK_SYS),
    .rst_n(RSTN),
    .start(div_go_q),
    .dividend(a_q),
    .divisor(b_q),
    .quotient(quo),
    .remainder(rem),
    .done(div_done)
  );

  // sign-extend a 16-bit word so narrow forms share the 32-bit datapath
  function [31:0] sx;
    input [31:0] v;
    input w;
    begin
      sx = w ? v : {{16{v[15]}}, v[15:0]};
    end
  endfunction

  // read address for word k of the operand list
  function [15:0] rd_addr;
    input [2:0] k;
    input w;
    input [15:0] p;
    input [15:0] q;
    begin
      if (w) begin
        rd_addr = (k[1] ? q : p) + {15'h0000, k[0]};
      end else begin
        rd_addr = k[0] ? q : p;
      end
    end
  endfunction

  // ****************************
  // sequencer
  // ****************************
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= ST_IDLE;
      op_q <= 4'h0;
      wide_q <= 1'b0;
      s1_q <= `PDMA_ZERO16;
      s2_q <= `PDMA_ZERO16;
      d_q <= `PDMA_ZERO16;
      n_q <= `PDMA_ZERO16;
      rcnt_q <= 3'h0;
      rtot_q <= 3'h0;
      wcnt_q <= 3'h0;
      wtot_q <= 3'h0;
      a_q <= 32'h00000000;
      b_q <= 32'h00000000;
      r_q <= 32'h00000000;
      r2_q <= 32'h00000000;
      div_go_q <= 1'b0;
      DONE <= 1'b0;
      DIV_ZERO_ERR <= 1'b0;
      MEM_RD <= 1'b0;
      MEM_WR <= 1'b0;
      MEM_ADDR <= `PDMA_ZERO16;
      MEM_WDATA <= `PDMA_ZERO16;
    end else begin
      DONE <= 1'b0;
      DIV_ZERO_ERR <= 1'b0;
      MEM_RD <= 1'b0;
      MEM_WR <= 1'b0;
      div_go_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (fire) begin
            op_q <= OPCODE;
            wide_q <= WIDE;
            n_q <= COUNT;
            a_q <= 32'h00000000;
            b_q <= 32'h00000000;
            rcnt_q <= 3'h0;
            wcnt_q <= 3'h0;
            if (OPCODE == `PDMA_OP_XCHG) begin
              s1_q <= DST_ADDR;
              s2_q <= SRC2_ADDR;
              rtot_q <= WIDE ? 3'h4 : 3'h2;
            end else if (OPCODE == `PDMA_OP_INC || OPCODE == `PDMA_OP_DEC) begin
              s1_q <= DST_ADDR;
              s2_q <= DST_ADDR;
              rtot_q <= WIDE ? 3'h2 : 3'h1;
            end else if (OPCODE == `PDMA_OP_BLKCPY || OPCODE == `PDMA_OP_FILL) begin
              s1_q <= SRC1_ADDR;
              s2_q <= SRC1_ADDR;
              rtot_q <= WIDE ? 3'h2 : 3'h1;
            end else begin
              s1_q <= SRC1_ADDR;
              s2_q <= SRC2_ADDR;
              rtot_q <= WIDE ? 3'h4 : 3'h2;
            end
            d_q <= DST_ADDR;
            if ((OPCODE == `PDMA_OP_BLKCPY || OPCODE == `PDMA_OP_FILL) && COUNT == 16'h0000) begin
              state_q <= ST_FIN;
            end else if (OPCODE > `PDMA_OP_AND) begin
              state_q <= ST_FIN;
            end else begin
              state_q <= ST_RD;
            end
          end
        end
        ST_RD: begin
          MEM_RD <= 1'b1;
          MEM_ADDR <= rd_addr(rcnt_q, wide_q, s1_q, s2_q);
          state_q <= ST_RWAIT;
        end
        ST_RWAIT: begin
          if (!wide_q) begin
            if (rcnt_q[0]) b_q[15:0] <= MEM_RDATA;
            else a_q[15:0] <= MEM_RDATA;
          end else begin
            case (rcnt_q[1:0])
              2'h0: a_q[15:0] <= MEM_RDATA;
              2'h1: a_q[31:16] <= MEM_RDATA;
              2'h2: b_q[15:0] <= MEM_RDATA;
              default: b_q[31:16] <= MEM_RDATA;
            endcase
          end
          rcnt_q <= rcnt_q + 3'h1;
          state_q <= (rcnt_q + 3'h1 == rtot_q) ? ST_EXEC : ST_RD;
        end
        ST_EXEC: begin
          wcnt_q <= 3'h0;
          wtot_q <= wide_q ? 3'h2 : 3'h1;
          case (op_q)
            `PDMA_OP_BLKCPY, `PDMA_OP_FILL: r_q <= a_q;
            `PDMA_OP_XCHG: begin
              r_q <= b_q;
              r2_q <= a_q;
              wtot_q <= wide_q ? 3'h4 : 3'h2;
            end
            `PDMA_OP_ADD: r_q <= sx(a_q, wide_q) + sx(b_q, wide_q);
            `PDMA_OP_SUB: r_q <= sx(a_q, wide_q) - sx(b_q, wide_q);
            `PDMA_OP_MUL: r_q <= sx(a_q, wide_q) * sx(b_q, wide_q);
            `PDMA_OP_INC: r_q <= a_q + 32'h00000001;
            `PDMA_OP_DEC: r_q <= a_q - 32'h00000001;
            `PDMA_OP_AND: r_q <= a_q & b_q;
            default: r_q <= a_q;
          endcase
          if (op_q == `PDMA_OP_DIV || op_q == `PDMA_OP_REM) begin
            if (sx(b_q, wide_q) == 32'h00000000) begin
              DIV_ZERO_ERR <= 1'b1;
              state_q <= ST_FIN;
            end else begin
              a_q <= sx(a_q, wide_q);
              b_q <= sx(b_q, wide_q);
              div_go_q <= 1'b1;
              state_q <= ST_DIVW;
            end
          end else begin
            state_q <= ST_WR;
          end
        end
        ST_DIVW: begin
          if (div_done) begin
            state_q <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          // divider output registers settle one cycle after done
          r_q <= (op_q == `PDMA_OP_DIV) ? quo : rem;
          state_q <= ST_WR;
        end
        ST_WR: begin
          MEM_WR <= 1'b1;
          if (op_q == `PDMA_OP_XCHG && wcnt_q >= (wide_q ? 3'h2 : 3'h1)) begin
            MEM_ADDR <= s2_q + {15'h0000, wide_q & ~wcnt_q[0]};
            MEM_WDATA <= (wide_q && !wcnt_q[0]) ? r2_q[31:16] : r2_q[15:0];
            if (wide_q && wcnt_q == 3'h2) MEM_ADDR <= s2_q;
            if (wide_q && wcnt_q == 3'h3) MEM_ADDR <= s2_q + 16'h0001;
            if (wide_q) MEM_WDATA <= wcnt_q[0] ? r2_q[31:16] : r2_q[15:0];
          end else begin
            MEM_ADDR <= d_q + {15'h0000, wcnt_q[0]};
            MEM_WDATA <= wcnt_q[0] ? r_q[31:16] : r_q[15:0];
          end
          wcnt_q <= wcnt_q + 3'h1;
          if (wcnt_q + 3'h1 == wtot_q) begin
            if (stream && n_q > 16'h0001) begin
              n_q <= n_q - 16'h0001;
              d_q <= d_q + step;
              if (op_q == `PDMA_OP_BLKCPY) begin
                s1_q <= s1_q + step;
                s2_q <= s2_q + step;
                rcnt_q <= 3'h0;
                state_q <= ST_RD;
              end else begin
                wcnt_q <= 3'h0;
              end
            end else begin
              state_q <= ST_FIN;
            end
          end
        end
        default: begin
          DONE <= 1'b1;
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // pdma_unit

// [sim/pdma_store_model.sv]
// Purpose: operand store model facing the unit's memory port
// Assumes: read data is taken while the read strobe is high
// Notes: an idle data bus shows the inverse of the last word read
`timescale 1ns/1ps
module pdma_store_model (
  input wire clk,
  input wire rd,
  input wire wr,
  input wire [15:0] addr,
  input wire [15:0] wdata,
  output wire [15:0] rdata
);
  // ****
  // storage
  // ****
  reg [15:0] mem [0:255];
  reg [15:0] last_q = 16'h0000;
  assign rdata = rd ? mem[addr[7:0]] : ~last_q;
  always @(posedge clk) begin
    if (rd)
      last_q <= mem[addr[7:0]];
    if (wr)
      mem[addr[7:0]] <= wdata;
  end
endmodule // pdma_store_model

// [sim/pdma_unit_chk.sv]
// Purpose: port-level assertions for the data-move unit
// Assumes: single clock domain, async active-low reset
// Notes: acceptance is tracked here from the entry rules
`timescale 1ns/1ps
module pdma_unit_chk (
  input wire CLK_SYS,
  input wire RSTN,
  input wire START,
  input wire [3:0] OPCODE,
  input wire WIDE,
  input wire PULSE_FORM,
  input wire ENTRY_COND,
  input wire [15:0] SRC1_ADDR,
  input wire [15:0] DST_ADDR,
  input wire [15:0] COUNT,
  input wire READY,
  input wire DONE,
  input wire DIV_ZERO_ERR,
  input wire MEM_RD,
  input wire MEM_WR,
  input wire [15:0] MEM_ADDR
);
  // ****
  // acceptance tracking
  // ****
  reg ec_q;
  reg w_q;
  reg [3:0] op_q;
  reg [15:0] s1_q;
  reg [15:0] d_q;
  wire take = START && READY;
  wire acc = take && ENTRY_COND && !(PULSE_FORM && ec_q);
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      ec_q <= 1'b0;
      w_q <= 1'b0;
      op_q <= 4'h0;
      s1_q <= 16'h0000;
      d_q <= 16'h0000;
    end else if (take) begin
      ec_q <= ENTRY_COND;
      if (acc) begin
        op_q <= OPCODE;
        w_q <= WIDE;
        s1_q <= SRC1_ADDR;
        d_q <= DST_ADDR;
      end
    end
  end
  // ****
  // properties
  // ****
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RSTN);
  sequence add_rd;
    MEM_RD && MEM_ADDR == s1_q ##2 MEM_RD;
  endsequence
  sequence add_wb;
    MEM_WR && MEM_ADDR == d_q ##1 DONE;
  endsequence
  chk_add_walk: assert property (acc && OPCODE == 4'h3 && !WIDE |=> ##1 add_rd ##3 add_wb)
    else $error("add walk out of order");
  chk_copy_first: assert property (acc && OPCODE == 4'h0 && COUNT != 16'h0000 |=> ##1
    MEM_RD && MEM_ADDR == s1_q) else $error("copy does not read source first");
  chk_no_entry: assert property (take && !ENTRY_COND |=> READY &&
    !MEM_RD && !MEM_WR && !DONE) else $error("ran with entry condition off");
  chk_pulse_once: assert property (take && PULSE_FORM && ENTRY_COND && ec_q |=>
    READY && !MEM_RD && !MEM_WR && !DONE) else $error("pulse form ran twice");
  chk_zero_nowr: assert property (DIV_ZERO_ERR |-> !MEM_WR ##1 !MEM_WR ##1 !MEM_WR)
    else $error("write after divide by zero");
  chk_err_divop: assert property (DIV_ZERO_ERR |-> op_q == 4'h6 || op_q == 4'h7)
    else $error("divide error outside division");
  chk_done_once: assert property (DONE |=> !DONE)
    else $error("done held too long");
  chk_wr_dest: assert property (MEM_WR && op_q >= 4'h3 && op_q <= 4'hA |->
    MEM_ADDR == d_q || (w_q && MEM_ADDR == d_q + 16'h0001)) else $error("write off destination");
endmodule // pdma_unit_chk
bind pdma_unit pdma_unit_chk i_pdma_unit_chk (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .START(START),
  .OPCODE(OPCODE), .WIDE(WIDE), .PULSE_FORM(PULSE_FORM), .ENTRY_COND(ENTRY_COND),
  .SRC1_ADDR(SRC1_ADDR), .DST_ADDR(DST_ADDR), .COUNT(COUNT), .READY(READY), .DONE(DONE),
  .DIV_ZERO_ERR(DIV_ZERO_ERR), .MEM_RD(MEM_RD), .MEM_WR(MEM_WR), .MEM_ADDR(MEM_ADDR));

// [sim/tb_top.sv]
// Purpose: self-checking bench for the data-move and arithmetic unit
// Assumes: store model answers within the read strobe cycle
// Notes: memory is preset to 5555 so stray writes show up
`timescale 1ns/1ps
`include "pdma_defs.vh"
module tb_top;
  reg clk_sys = 1'b0;
  reg rstn = 1'b0;
  reg start = 1'b0;
  reg wide = 1'b0;
  reg pulse_form = 1'b0;
  reg entry_cond = 1'b0;
  reg [3:0] opcode = 4'h0;
  reg [15:0] src1 = 16'h0000;
  reg [15:0] src2 = 16'h0000;
  reg [15:0] dst = 16'h0000;
  reg [15:0] count = 16'h0000;
  wire ready, done, dz_err, mem_rd, mem_wr;
  wire [15:0] mem_addr, mem_wdata, mem_rdata;
  integer bad_count = 0;
  integer compares = 0;
  integer cycles = 0;
  integer i, j;
  reg got_done, got_err;
  reg [3:0] op;
  reg [31:0] a, b, e;
  always #5 clk_sys = ~clk_sys;
  pdma_unit i_pdma_unit (.CLK_SYS(clk_sys), .RSTN(rstn), .START(start), .OPCODE(opcode),
    .WIDE(wide), .PULSE_FORM(pulse_form), .ENTRY_COND(entry_cond), .SRC1_ADDR(src1),
    .SRC2_ADDR(src2), .DST_ADDR(dst), .COUNT(count), .READY(ready), .DONE(done),
    .DIV_ZERO_ERR(dz_err), .MEM_RD(mem_rd), .MEM_WR(mem_wr), .MEM_ADDR(mem_addr),
    .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata));
  pdma_store_model i_pdma_store_model (.clk(clk_sys), .rd(mem_rd), .wr(mem_wr),
    .addr(mem_addr), .wdata(mem_wdata), .rdata(mem_rdata));
  // ****
  // helpers
  // ****
  function [15:0] m16(input [7:0] ad);
    m16 = i_pdma_store_model.mem[ad];
  endfunction
  function [31:0] m32(input [7:0] ad);
    m32 = {i_pdma_store_model.mem[ad + 8'h01], i_pdma_store_model.mem[ad]};
  endfunction
  task put32(input [7:0] ad, input [31:0] v);
    begin
      i_pdma_store_model.mem[ad] = v[15:0];
      i_pdma_store_model.mem[ad + 8'h01] = v[31:16];
    end
  endtask
  function [31:0] calc(input [3:0] o, input w, input [31:0] p, input [31:0] q);
    reg signed [31:0] x, y;
    begin
      x = w ? p : {{16{p[15]}}, p[15:0]};
      y = w ? q : {{16{q[15]}}, q[15:0]};
      case (o)
        `PDMA_OP_ADD: calc = x + y;
        `PDMA_OP_SUB: calc = x - y;
        `PDMA_OP_MUL: calc = x * y;
        `PDMA_OP_DIV: calc = x / y;
        `PDMA_OP_REM: calc = x % y;
        default: calc = x & y;
      endcase
    end
  endfunction
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task cmp_flag(input got, input exp);
    cmp({31'h0, got}, {31'h0, exp});
  endtask
  // one request, then wait a bounded time for done or error
  task run(input [3:0] o, input w, input pf, input ec, input [15:0] s1, input [15:0] s2,
    input [15:0] d, input [15:0] n);
    integer k;
    begin
      @(negedge clk_sys);
      opcode = o;
      wide = w;
      pulse_form = pf;
      entry_cond = ec;
      src1 = s1;
      src2 = s2;
      dst = d;
      count = n;
      start = 1'b1;
      @(negedge clk_sys);
      start = 1'b0;
      got_done = 1'b0;
      got_err = 1'b0;
      for (k = 0; k < 60 && !got_done && !got_err; k = k + 1) begin
        @(negedge clk_sys);
        got_done = (done === 1'b1);
        got_err = (dz_err === 1'b1);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("compares=%0d mismatches=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // ****
  // scenarios
  // ****
  task test_copy;
    begin
      for (i = 0; i < 4; i = i + 1)
        i_pdma_store_model.mem[8'h40 + i] = 16'hA000 + i;
      run(`PDMA_OP_BLKCPY, 0, 0, 1, 16'h0040, 16'h0000, 16'h0050, 16'h0004);
      cmp_flag(got_done, 1'b1);
      for (i = 0; i < 5; i = i + 1)
        cmp(m16(8'h50 + i), i < 4 ? 16'hA000 + i : 16'h5555);
      run(`PDMA_OP_BLKCPY, 1, 0, 1, 16'h0040, 16'h0000, 16'h0060, 16'h0002);
      for (i = 0; i < 5; i = i + 1)
        cmp(m16(8'h60 + i), i < 4 ? 16'hA000 + i : 16'h5555);
      $display("test copy finished");
    end
  endtask
  task test_fill;
    begin
      i_pdma_store_model.mem[8'h70] = 16'h1234;
      run(`PDMA_OP_FILL, 0, 0, 1, 16'h0070, 16'h0000, 16'h0080, 16'h0003);
      for (i = 0; i < 4; i = i + 1)
        cmp(m16(8'h80 + i), i < 3 ? 16'h1234 : 16'h5555);
      run(`PDMA_OP_FILL, 0, 0, 1, 16'h0070, 16'h0000, 16'h0090, 16'h0000);
      cmp_flag(got_done, 1'b1);
      cmp(m16(8'h90), 16'h5555);
      run(`PDMA_OP_FILL, 1, 0, 1, 16'h0040, 16'h0000, 16'h0090, 16'h0002);
      for (i = 0; i < 5; i = i + 1)
        cmp(m16(8'h90 + i), i < 4 ? 16'hA000 + i % 2 : 16'h5555);
      cmp(m16(8'h70), 16'h1234);
      $display("test fill finished");
    end
  endtask
  task test_xchg;
    begin
      put32(8'h10, 32'h11112222);
      put32(8'h20, 32'h33334444);
      run(`PDMA_OP_XCHG, 1, 0, 1, 16'h0000, 16'h0020, 16'h0010, 16'h0000);
      cmp(m32(8'h10), 32'h33334444);
      cmp(m32(8'h20), 32'h11112222);
      run(`PDMA_OP_XCHG, 0, 0, 1, 16'h0000, 16'h0020, 16'h0010, 16'h0000);
      cmp(m32(8'h10), 32'h33332222);
      cmp(m32(8'h20), 32'h11114444);
      $display("test exchange finished");
    end
  endtask
  task test_arith;
    begin
      for (i = 0; i < 2; i = i + 1)
        for (j = 0; j < 6; j = j + 1) begin
          op = j == 5 ? `PDMA_OP_AND : `PDMA_OP_ADD + j;
          a = i ? 32'hFFF0FFF9 : 32'h5555FFF9;
          b = i ? 32'h00000013 : 32'h55550003;
          e = calc(op, i, a, b);
          put32(8'h10, a);
          put32(8'h20, b);
          put32(8'h30, 32'h55555555);
          run(op, i, 0, 1, 16'h0010, 16'h0020, 16'h0030, 16'h0000);
          cmp(m32(8'h30), i ? e : {16'h5555, e[15:0]});
          cmp(m32(8'h10), a);
        end
      $display("test arithmetic finished");
    end
  endtask
  task test_divzero;
    begin
      for (j = 0; j < 2; j = j + 1) begin
        put32(8'h10, 32'h00000007);
        put32(8'h20, 32'h00000000);
        i_pdma_store_model.mem[8'h30] = 16'h5555;
        run(`PDMA_OP_DIV + j, 0, 0, 1, 16'h0010, 16'h0020, 16'h0030, 16'h0000);
        cmp_flag(got_err, 1'b1);
        cmp(m16(8'h30), 16'h5555);
      end
      $display("test divide by zero finished");
    end
  endtask
  task test_incdec;
    begin
      put32(8'h30, 32'h0000FFFF);
      run(`PDMA_OP_INC, 1, 0, 1, 16'h0000, 16'h0000, 16'h0030, 16'h0000);
      cmp(m32(8'h30), 32'h00010000);
      run(`PDMA_OP_DEC, 1, 0, 1, 16'h0000, 16'h0000, 16'h0030, 16'h0000);
      cmp(m32(8'h30), 32'h0000FFFF);
      i_pdma_store_model.mem[8'h30] = 16'h0000;
      run(`PDMA_OP_DEC, 0, 0, 1, 16'h0000, 16'h0000, 16'h0030, 16'h0000);
      cmp(m32(8'h30), 32'h0000FFFF);
      $display("test increment finished");
    end
  endtask
  task test_pulse;
    begin
      i_pdma_store_model.mem[8'h30] = 16'h0007;
      run(`PDMA_OP_INC, 0, 1, 0, 16'h0000, 16'h0000, 16'h0030, 16'h0000);
      cmp_flag(got_done, 1'b0);
      for (j = 0; j < 2; j = j + 1) begin
        run(`PDMA_OP_INC, 0, 1, 1, 16'h0000, 16'h0000, 16'h0030, 16'h0000);
        cmp_flag(got_done, j == 0);
        cmp(m16(8'h30), 16'h0008);
      end
      run(`PDMA_OP_INC, 0, 0, 0, 16'h0000, 16'h0000, 16'h0030, 16'h0000);
      cmp(m16(8'h30), 16'h0008);
      run(4'hB, 0, 0, 1, 16'h0000, 16'h0000, 16'h0030, 16'h0000);
      cmp_flag(got_done, 1'b1);
      cmp(m16(8'h30), 16'h0008);
      $display("test pulse form finished");
    end
  endtask
  // ****
  // main sequence and hang guard
  // ****
  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles == 6000) begin
      bad_count = bad_count + 1;
      give_verdict;
    end
  end
  initial begin
    for (i = 0; i < 256; i = i + 1)
      i_pdma_store_model.mem[i] = 16'h5555;
    repeat (4) @(negedge clk_sys);
    rstn = 1'b1;
    test_copy;
    test_fill;
    test_xchg;
    test_arith;
    test_divzero;
    test_incdec;
    test_pulse;
    give_verdict;
  end
endmodule // tb_top
